// *** fms_core.sv ***
// Serial flash mode control: continuous quad read, status register volatility,
// soft reset, address width, and discovery bytes 68h..6Fh.
// Assumes SPI mode 0 sampled by I_MCLK, link clock far slower than I_MCLK.
`timescale 1ns/100ps
`default_nettype none
module fms_core
  import fms_pkg::*;
(
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  // Serial link
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic [3:0] I_QUAD_IO_LINES,
  // Non-volatile store and width mode
  input wire logic [7:0] I_NV_SR,
  input wire logic [1:0] I_CMD_WIDTH,
  input wire logic [2:0] I_DISC_ADDR,
  // Status
  output logic [7:0] O_DISC_DATA,
  output logic [7:0] O_SR,
  output logic [7:0] O_NV_SR_WDATA,
  output logic O_NV_SR_WE,
  output logic O_ADDR_4B,
  output logic O_CONT_READ,
  output logic O_SOFT_RESET
);
  typedef enum {ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DATA, ST_WRSR, ST_SKIP} fms_state_t;

  // ----------------------------------------
  // Discovery bytes
  // ----------------------------------------
  function automatic logic [7:0] fms_disc(input logic [2:0] idx);
    case (idx)
      3'h0: fms_disc = DISC_B68;
      3'h1: fms_disc = DISC_B69;
      3'h2: fms_disc = DISC_B6A;
      3'h3: fms_disc = DISC_B6B;
      3'h4: fms_disc = DISC_B6C;
      3'h5: fms_disc = DISC_B6D;
      3'h6: fms_disc = DISC_B6E;
      default: fms_disc = DISC_B6F;
    endcase
  endfunction : fms_disc

  // ----------------------------------------
  // Pin synchronisers, change once stages two and three agree
  // ----------------------------------------
  logic [5:0] s1, s2, s3, pin;
  logic sclk_q;
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      s1 <= 6'h1f;
      s2 <= 6'h1f;
      s3 <= 6'h1f;
      pin <= 6'h1f;
      sclk_q <= 1'b0;
    end
    else
    begin
      s1 <= {I_SCLK, I_CS_N, I_QUAD_IO_LINES};
      s2 <= s1;
      s3 <= s2;
      for (int k = 0; k < 6; k++)
        if (s2[k] == s3[k])
          pin[k] <= s3[k];
      sclk_q <= pin[5];
    end
  end
  wire logic sclk_rise = pin[5] && !sclk_q;
  wire logic cs_n = pin[4];
  wire logic [3:0] dq = pin[3:0];

  // ----------------------------------------
  // Command interpreter
  // ----------------------------------------
  fms_state_t state, next_state;
  logic [7:0] shreg, next_shreg;
  logic [5:0] cnt, next_cnt;
  logic [3:0] ones, next_ones;
  logic [7:0] sr, next_sr;
  logic nv_we, next_nv_we;
  logic v_we, next_v_we;
  logic rst_armed, next_rst_armed;
  logic addr_4b, next_addr_4b;
  logic cont, next_cont;
  logic cont_keep, next_cont_keep;
  logic loaded, next_loaded;
  logic soft_rst, next_soft_rst;
  logic nv_pulse, next_nv_pulse;
  logic [7:0] bits_in;
  logic [5:0] step;
  logic [5:0] addr_clks;

  always_comb
  begin
    next_state = state;
    next_shreg = shreg;
    next_cnt = cnt;
    next_ones = ones;
    next_sr = sr;
    next_nv_we = nv_we;
    next_v_we = v_we;
    next_rst_armed = rst_armed;
    next_addr_4b = addr_4b;
    next_cont = cont;
    next_cont_keep = cont_keep;
    next_loaded = 1'b1;
    next_soft_rst = 1'b0;
    next_nv_pulse = 1'b0;
    // shift width follows current command width
    case (I_CMD_WIDTH)
      2'd2: begin bits_in = {shreg[3:0], dq}; step = 6'd4; end
      2'd1: begin bits_in = {shreg[5:0], dq[1:0]}; step = 6'd2; end
      default: begin bits_in = {shreg[6:0], dq[0]}; step = 6'd1; end
    endcase
    addr_clks = addr_4b ? 6'd8 : 6'd6;
    if (!loaded)
      next_sr = I_NV_SR;
    if (cs_n)
    begin
      if (state == ST_DATA && !cont_keep)
        next_cont = 1'b0;
      next_state = ST_IDLE;
      next_cnt = 6'd0;
      next_ones = 4'd0;
    end
    else if (sclk_rise)
    begin
      next_shreg = bits_in;
      next_cnt = cnt + step;
      case (state)
        ST_IDLE:
        begin
          next_cnt = cont ? 6'd1 : step;
          next_shreg = cont ? {4'h0, dq} : bits_in;
          next_state = cont ? ST_ADDR : ST_CMD;
          next_ones = (cont && dq == 4'hf) ? 4'd1 : 4'd0;
        end
        ST_CMD:
          if (next_cnt == 6'd8)
          begin
            next_cnt = 6'd0;
            next_state = ST_SKIP;
            next_rst_armed = 1'b0;
            case (bits_in)
              OP_WREN: next_nv_we = 1'b1;
              OP_VWREN: next_v_we = 1'b1;
              OP_EN4B: next_addr_4b = 1'b1;
              OP_EX4B: next_addr_4b = 1'b0;
              OP_RSTEN: next_rst_armed = 1'b1;
              OP_RST:
                if (rst_armed)
                begin
                  next_soft_rst = 1'b1;
                  next_addr_4b = 1'b0;
                  next_cont = 1'b0;
                  next_nv_we = 1'b0;
                  next_v_we = 1'b0;
                  next_sr = I_NV_SR;
                end
              OP_WRSR:
                if (nv_we || v_we)
                  next_state = ST_WRSR;
              OP_QIOR: next_state = ST_ADDR;
              default: next_state = ST_SKIP;
            endcase
          end
        ST_ADDR:
        begin
          // all-ones on the quad lines counts toward the forced exit
          next_ones = (dq == 4'hf) ? ones + 4'd1 : 4'd0;
          next_cnt = cnt + 6'd1;
          if (cont && next_ones == (addr_4b ? 4'(ESC_CLK_4B) : 4'(ESC_CLK_3B)))
          begin
            next_cont = 1'b0;
            next_state = ST_SKIP;
          end
          else if (next_cnt == addr_clks)
          begin
            next_cnt = 6'd0;
            next_state = ST_MODE;
          end
        end
        ST_MODE:
        begin
          next_shreg = {shreg[3:0], dq};
          next_cnt = cnt + 6'd1;
          if (cont)
            next_ones = (dq == 4'hf) ? ones + 4'd1 : 4'd0;
          if (cont && next_ones == (addr_4b ? 4'(ESC_CLK_4B) : 4'(ESC_CLK_3B)))
          begin
            next_cont = 1'b0;
            next_state = ST_SKIP;
          end
          else if (next_cnt == 6'd2)
          begin
            // entry only with quad enable set
            next_cont_keep = ({shreg[3:0], dq} == MODE_CONT) && sr[QE_POS];
            if ({shreg[3:0], dq} == MODE_CONT && sr[QE_POS])
              next_cont = 1'b1;
            next_state = ST_DATA;
          end
        end
        ST_WRSR:
          if (next_cnt == 6'd8)
          begin
            next_sr = bits_in;
            next_nv_pulse = nv_we && !v_we;
            next_nv_we = 1'b0;
            next_v_we = 1'b0;
            next_state = ST_SKIP;
          end
        default: next_cnt = 6'd0;
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      cnt <= 6'd0;
      ones <= 4'd0;
      sr <= SR_RESET;
      nv_we <= 1'b0;
      v_we <= 1'b0;
      rst_armed <= 1'b0;
      addr_4b <= 1'b0;
      cont <= 1'b0;
      cont_keep <= 1'b0;
      loaded <= 1'b0;
      soft_rst <= 1'b0;
      nv_pulse <= 1'b0;
    end
    else
    begin
      state <= next_state;
      shreg <= next_shreg;
      cnt <= next_cnt;
      ones <= next_ones;
      sr <= next_sr;
      nv_we <= next_nv_we;
      v_we <= next_v_we;
      rst_armed <= next_rst_armed;
      addr_4b <= next_addr_4b;
      cont <= next_cont;
      cont_keep <= next_cont_keep;
      loaded <= next_loaded;
      soft_rst <= next_soft_rst;
      nv_pulse <= next_nv_pulse;
    end
  end

  // Discovery data registered; the byte never depends on mode state
  logic [7:0] disc_q;
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      disc_q <= 8'h00;
    else
      disc_q <= fms_disc(I_DISC_ADDR);
  end

  assign O_DISC_DATA = disc_q;
  assign O_SR = sr;
  assign O_NV_SR_WDATA = sr;
  assign O_NV_SR_WE = nv_pulse;
  assign O_ADDR_4B = addr_4b;
  assign O_CONT_READ = cont;
  assign O_SOFT_RESET = soft_rst;
endmodule : fms_core
`default_nettype wire

// *** fms_core_monitor.sv ***
// Concurrent checks on the ports of fms_core, attached by bind.
// Assumes I_NV_SR and I_DISC_ADDR are held levels from the bench.
`timescale 1ns/100ps
`default_nettype none
module fms_core_monitor
  import fms_pkg::*;
(
  // Watched ports
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_CS_N,
  input wire logic [7:0] I_NV_SR,
  input wire logic [2:0] I_DISC_ADDR,
  input wire logic [7:0] O_DISC_DATA,
  input wire logic [7:0] O_SR,
  input wire logic [7:0] O_NV_SR_WDATA,
  input wire logic O_NV_SR_WE,
  input wire logic O_ADDR_4B,
  input wire logic O_CONT_READ,
  input wire logic O_SOFT_RESET
);
  localparam logic [63:0] TBL = 64'h0090_48ff_e850_c1a5;
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  disc_map_a: assert property (1 |=> O_DISC_DATA == TBL[63 - 8 * $past(I_DISC_ADDR) -: 8])
    else $error("discovery byte wrong");
  we_pulse_a: assert property (O_NV_SR_WE |=> !O_NV_SR_WE)
    else $error("store pulse too long");
  we_data_a: assert property (O_NV_SR_WE |-> O_NV_SR_WDATA == O_SR)
    else $error("store data differs");
  rst_pulse_a: assert property (O_SOFT_RESET |=> !O_SOFT_RESET)
    else $error("reset pulse too long");
  sr_load_a: assert property ($rose(I_RST_N) |-> ##[1:2] O_SR == I_NV_SR)
    else $error("status not loaded");
  soft_state_a: assert property (O_SOFT_RESET |-> ##[0:1] !O_ADDR_4B && !O_CONT_READ)
    else $error("soft reset left a mode");
  cont_qe_a: assert property ($rose(O_CONT_READ) |-> O_SR[QE_POS])
    else $error("quad read without enable");
  idle_hold_a: assert property (I_CS_N [*8] |=> $stable(O_ADDR_4B) && $stable(O_SR))
    else $error("state moved while idle");
  cover property ($rose(O_CONT_READ));
  cover property (O_SOFT_RESET);
  cover property (O_NV_SR_WE);
endmodule : fms_core_monitor
bind fms_core fms_core_monitor fms_core_monitor_inst (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N),
  .I_CS_N(I_CS_N), .I_NV_SR(I_NV_SR), .I_DISC_ADDR(I_DISC_ADDR), .O_DISC_DATA(O_DISC_DATA),
  .O_SR(O_SR), .O_NV_SR_WDATA(O_NV_SR_WDATA), .O_NV_SR_WE(O_NV_SR_WE),
  .O_ADDR_4B(O_ADDR_4B), .O_CONT_READ(O_CONT_READ), .O_SOFT_RESET(O_SOFT_RESET));
`default_nettype wire

// *** fms_host.sv ***
// Host controller model: mode 0 link, 125 ns clock, MSB first.
// Assumes the bench orders commands; the clock stands still outside frames.
`timescale 1ns/100ps
`default_nettype none
module fms_host (
  // Link
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_io
);
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
  end
  task automatic sel();
    o_cs_n = 1'b0;
    // Odd offset keeps every link edge after the select clear of the system clock edges; the select itself falls on a negedge
    #61.2;
  endtask : sel
  // Width w is 1, 2 or 4 lines per the current command width
  task automatic put(input logic [7:0] b, input int w);
    for (int k = 8 / w - 1; k >= 0; k--)
    begin
      o_io = (w == 4) ? b[k*4+:4] : (w == 2) ? {2'b0, b[k*2+:2]} : {3'b0, b[k]};
      #62.5 o_sclk = 1'b1;
      #62.5 o_sclk = 1'b0;
    end
  endtask : put
  // Released lines flip so a stale value is never mistaken for data
  task automatic desel();
    #62.5 o_cs_n = 1'b1;
    o_io = ~o_io;
    #125;
  endtask : desel
endmodule : fms_host
`default_nettype wire

// *** fms_pkg.sv ***
// Constants for the flash mode-switch block: discovery bytes, opcodes, timing.
// Assumes a single-bit, dual or quad SPI link sampled by a fast system clock.
package fms_pkg;
  // ----------------------------------------
  // Discovery table window
  // ----------------------------------------
  localparam logic [7:0] DISC_BASE = 8'h68;
  localparam logic [7:0] DISC_B68 = 8'h00;
  localparam logic [7:0] DISC_B69 = 8'h90;
  localparam logic [7:0] DISC_B6A = 8'h48;
  localparam logic [7:0] DISC_B6B = 8'hff;
  localparam logic [7:0] DISC_B6C = 8'he8;
  localparam logic [7:0] DISC_B6D = 8'h50;
  localparam logic [7:0] DISC_B6E = 8'hc1;
  localparam logic [7:0] DISC_B6F = 8'ha5;
  // ----------------------------------------
  // Opcodes and mode bits
  // ----------------------------------------
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_VWREN = 8'h50;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_RSTEN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_EN4B = 8'hb7;
  localparam logic [7:0] OP_EX4B = 8'he9;
  localparam logic [7:0] OP_QIOR = 8'heb;
  localparam logic [7:0] OP_QPI = 8'h38;
  localparam logic [7:0] MODE_CONT = 8'ha5;
  localparam logic [7:0] MODE_END = 8'h00;
  // ----------------------------------------
  // Field positions and counts
  // ----------------------------------------
  localparam int QE_POS = 6;
  localparam int ESC_CLK_3B = 8;
  localparam int ESC_CLK_4B = 10;
  localparam int DUMMY_CLK = 4;
  localparam logic [7:0] SR_RESET = 8'h40;
endpackage : fms_pkg

// *** test_fms_core.sv ***
// Self-checking bench for fms_core with the fms_host link model.
// Assumes frames are separated by idle time longer than the input sync.
`timescale 1ns/100ps
`default_nettype none
module test_fms_core;
  localparam logic [7:0] EXP [8] = '{8'h00, 8'h90, 8'h48, 8'hff, 8'he8, 8'h50, 8'hc1, 8'ha5};
  logic I_MCLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic [7:0] I_NV_SR = 8'h40;
  logic [1:0] I_CMD_WIDTH = 2'h0;
  logic [2:0] I_DISC_ADDR = 3'h0;
  wire logic sclk;
  wire logic cs_n;
  wire logic [3:0] io;
  logic [7:0] disc, sr, nv_wdata;
  logic we, a4b, cont, srst;
  int failures = 0;
  int n_tests = 0;
  int we_cnt = 0;
  int rs_cnt = 0;
  always #2.5 I_MCLK = ~I_MCLK;
  // Pulses counted mid-cycle; the far-side store keeps each written value
  always @(negedge I_MCLK)
  begin
    we_cnt += int'(we === 1'b1);
    rs_cnt += int'(srst === 1'b1);
    if (we === 1'b1)
      I_NV_SR = nv_wdata;
  end
  fms_host fms_host_inst (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(io));
  fms_core fms_core_inst (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_SCLK(sclk), .I_CS_N(cs_n),
    .I_QUAD_IO_LINES(io), .I_NV_SR(I_NV_SR), .I_CMD_WIDTH(I_CMD_WIDTH),
    .I_DISC_ADDR(I_DISC_ADDR), .O_DISC_DATA(disc), .O_SR(sr), .O_NV_SR_WDATA(nv_wdata),
    .O_NV_SR_WE(we), .O_ADDR_4B(a4b), .O_CONT_READ(cont), .O_SOFT_RESET(srst));
  task automatic print_verdict();
    $display("Checks %0d, failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One opcode frame, optional data byte, on w lines
  task automatic cmd(input logic [7:0] op, input int w, input bit wd = 0, input logic [7:0] d = 0);
    @(negedge I_MCLK) I_CMD_WIDTH = (w == 4) ? 2'h2 : (w == 2) ? 2'h1 : 2'h0;
    fms_host_inst.sel();
    fms_host_inst.put(op, w);
    if (wd)
      fms_host_inst.put(d, w);
    fms_host_inst.desel();
  endtask : cmd
  // Quad read frame; op=0 for a frame already in no-opcode mode
  task automatic qread(input logic [7:0] mode, input bit op, input int nib);
    @(negedge I_MCLK);
    fms_host_inst.sel();
    if (op)
      fms_host_inst.put(8'heb, 1);
    repeat (nib / 2) fms_host_inst.put(8'h00, 4);
    fms_host_inst.put(mode, 4);
    fms_host_inst.desel();
  endtask : qread
  task automatic fexit(input int nib);
    @(negedge I_MCLK);
    fms_host_inst.sel();
    repeat (nib / 2) fms_host_inst.put(8'hff, 4);
    fms_host_inst.desel();
  endtask : fexit
  task automatic disc_all();
    for (int i = 0; i < 8; i++)
    begin
      @(negedge I_MCLK) I_DISC_ADDR = 3'(i);
      @(negedge I_MCLK);
      chk(disc, EXP[i]);
    end
  endtask : disc_all
  initial
  begin
    repeat (20) @(negedge I_MCLK);
    I_RST_N = 1'b1;
    repeat (6) @(negedge I_MCLK);
    chk(sr, 8'h40);
    disc_all();
    for (int w = 1; w <= 4; w *= 2)
    begin
      cmd(8'hb7, w);
      chk({7'h0, a4b}, 8'h01);
      cmd(8'he9, w);
      chk({7'h0, a4b}, 8'h00);
    end
    cmd(8'h01, 1, 1, 8'h55);
    chk(sr, 8'h40);
    cmd(8'h06, 1);
    cmd(8'h01, 1, 1, 8'h44);
    chk(sr, 8'h44);
    chk(I_NV_SR, 8'h44);
    chk(8'(we_cnt), 8'h01);
    cmd(8'h50, 1);
    cmd(8'h01, 1, 1, 8'h00);
    chk(sr, 8'h00);
    chk(8'(we_cnt), 8'h01);
    qread(8'ha5, 1, 6);
    chk({7'h0, cont}, 8'h00);
    cmd(8'h50, 1);
    cmd(8'h01, 1, 1, 8'h4c);
    qread(8'ha5, 1, 6);
    chk({7'h0, cont}, 8'h01);
    disc_all();
    qread(8'h00, 0, 6);
    chk({7'h0, cont}, 8'h00);
    qread(8'ha5, 1, 6);
    fexit(8);
    chk({7'h0, cont}, 8'h00);
    cmd(8'hb7, 1);
    qread(8'ha5, 1, 8);
    chk({7'h0, cont}, 8'h01);
    fexit(10);
    chk({7'h0, cont}, 8'h00);
    cmd(8'h99, 1);
    cmd(8'h66, 1);
    cmd(8'h06, 1);
    cmd(8'h99, 1);
    chk(8'(rs_cnt), 8'h00);
    for (int w = 1; w <= 4; w *= 2)
    begin
      cmd(8'hb7, w);
      cmd(8'h66, w);
      cmd(8'h99, w);
      chk({7'h0, a4b}, 8'h00);
      chk(sr, 8'h44);
    end
    chk(8'(rs_cnt), 8'h03);
    // Mid-run reset: the volatile value must give way to the stored one
    cmd(8'h50, 1);
    cmd(8'h01, 1, 1, 8'h0c);
    chk(sr, 8'h0c);
    @(negedge I_MCLK);
    I_RST_N = 1'b0;
    repeat (4) @(negedge I_MCLK);
    I_RST_N = 1'b1;
    repeat (6) @(negedge I_MCLK);
    chk(sr, 8'h44);
    print_verdict();
  end
  initial
  begin
    #200000;
    failures++;
    $display("Error at %0t: run did not finish", $time);
    print_verdict();
  end
endmodule : test_fms_core
`default_nettype wire
